// >>> logic/wr_capture_pkg.sv
// Purpose: Shared constants and carriers for the write-port input capture.
// Assumes: The eight-bit configuration with a four-beat burst.
// Notes: One address is taken per write; four data beats follow it.
package wr_capture_pkg;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 20;
    localparam int BEATS = 4;
    localparam int FIFO_DEPTH = 16;
    localparam int LOW_LSB = 0;
    localparam int HIGH_LSB = 4;
    localparam int NIB_W = 4;
    localparam logic [1:0] BEAT_RESET = 2'h0;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [1:0] beat;
        logic [DATA_W-1:0] data;
        logic [1:0] keep;
    } beat_t;

    localparam int BEAT_W = $bits(beat_t);
endpackage

// >>> logic/beat_fifo.sv
// Purpose: Synchronous FIFO with valid and ready on both sides.
// Assumes: Depth is a power of two.
// Notes: Full and empty follow the stored count.
`timescale 1ns/1ns
module beat_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input wire logic clk, // Clock.
    input wire logic reset_n, // Synchronous reset, active low.
    input wire logic [WIDTH-1:0] in_data, // Write data.
    input wire logic in_valid, // Write request.
    output logic in_ready, // Space available.
    output logic [WIDTH-1:0] out_data, // Head word.
    output logic out_valid, // Head word present.
    input wire logic out_ready // Drain accepts.
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic push;
    logic pop;

    assign in_ready = (count != (AW+1)'(DEPTH));
    assign out_valid = (count != '0);
    assign out_data = mem[rd_ptr];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_ff @(posedge clk)
    begin
        if (push)
        begin
            mem[wr_ptr] <= in_data;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end
        else
        begin
            if (push)
            begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop)
            begin
                rd_ptr <= rd_ptr + 1'b1;
            end
            count <= count + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

// >>> logic/sram_write_port_capture.sv
// Purpose: Captures write commands, double-rate data and nibble masks for the array.
// Assumes: pos_data/neg_data are the beats already taken on the rising and falling clock halves.
// Notes: Notes on behaviour follow.
// Notes on behaviour
// (RL1) Data is taken on both clock halves while a write is active, eight bits wide here.
// (RL2) A low write select on the rising edge starts a write.
// (RL3) A high write select deselects the port and data is ignored.
// (RL4) Two active-low nibble masks are taken on both halves during active writes.
// (RL5) The low mask governs bits 3..0 and the high mask bits 7..4.
// (RL6) Each mask is taken on the same edge as the data beat it qualifies.
// (RL7) A high mask discards its nibble so the stored bits stay unchanged.
// (RL8) The address is taken on the rising edge of a write and ignored when deselected.
`timescale 1ns/1ns
module sram_write_port_capture
    import wr_capture_pkg::*;
(
    input wire logic clk, // Core clock.
    input wire logic reset_n, // Synchronous reset, active low.
    input wire logic write_port_select_n, // Write select, active low.
    input wire logic [ADDR_W-1:0] addr_in, // Shared address.
    input wire logic [DATA_W-1:0] pos_data, // Beat from the rising half.
    input wire logic [DATA_W-1:0] neg_data, // Beat from the falling half.
    input wire logic [1:0] pos_mask_n, // {high,low} nibble masks, rising half.
    input wire logic [1:0] neg_mask_n, // {high,low} nibble masks, falling half.
    output logic [BEAT_W-1:0] beat_out, // Captured beat to the array.
    output logic beat_valid, // Beat present.
    input wire logic beat_ready, // Array accepts the beat.
    output logic busy // Write burst in progress.
);
    logic sel_n_s1;
    logic sel_n_s2;
    logic [ADDR_W-1:0] addr_s1;
    logic [ADDR_W-1:0] addr_s2;
    logic [DATA_W-1:0] pd_s1;
    logic [DATA_W-1:0] pd_s2;
    logic [DATA_W-1:0] nd_s1;
    logic [DATA_W-1:0] nd_s2;
    logic [1:0] pm_s1;
    logic [1:0] pm_s2;
    logic [1:0] nm_s1;
    logic [1:0] nm_s2;
    logic active;
    logic last_slot;
    logic [1:0] beat_idx;
    logic [ADDR_W-1:0] wr_addr;
    beat_t rise_beat;
    beat_t fall_beat;
    beat_t [1:0] push_pair;
    logic pushing;
    logic fifo_in_ready;
    beat_t [1:0] fifo_pair;
    logic fifo_valid;
    logic emit;
    logic fifo_pop;
    logic half_sel;

    function automatic logic [1:0] keep_of(input logic [1:0] mask_n);
        return ~mask_n; // RL5
    endfunction

    // Masked nibbles are cleared so a dropped nibble can never leak into the array.
    function automatic beat_t make_beat(
        input logic [ADDR_W-1:0] addr,
        input logic [1:0] idx,
        input logic [DATA_W-1:0] data,
        input logic [1:0] mask_n
    );
        beat_t b;
        b.addr = addr;
        b.beat = idx;
        b.data = data; // RL1
        b.keep = keep_of(mask_n); // RL4 RL6
        b.data[LOW_LSB +: NIB_W] = b.keep[0] ? data[LOW_LSB +: NIB_W] : '0; // RL7
        b.data[HIGH_LSB +: NIB_W] = b.keep[1] ? data[HIGH_LSB +: NIB_W] : '0; // RL7
        return b;
    endfunction

    // Pin inputs pass two flops before use.
    always_ff @(posedge clk)
    begin
        sel_n_s1 <= write_port_select_n;
        sel_n_s2 <= sel_n_s1;
        addr_s1 <= addr_in;
        addr_s2 <= addr_s1;
        pd_s1 <= pos_data;
        pd_s2 <= pd_s1;
        nd_s1 <= neg_data;
        nd_s2 <= nd_s1;
        pm_s1 <= pos_mask_n;
        pm_s2 <= pm_s1;
        nm_s1 <= neg_mask_n;
        nm_s2 <= nm_s1;
    end

    // A select is looked at only when idle or in the last clock of a burst, so every burst runs two clocks.
    assign last_slot = beat_idx[1];

    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            active <= 1'b0;
        end
        else if (!active || last_slot)
        begin
            active <= !sel_n_s2; // RL2 RL3
        end
    end

    // Beat numbers run 0 and 1 in the first clock of a burst, 2 and 3 in the second.
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            beat_idx <= BEAT_RESET;
        end
        else if (!active || last_slot)
        begin
            beat_idx <= BEAT_RESET;
        end
        else
        begin
            beat_idx <= beat_idx + 2'h2;
        end
    end

    // The address is held for the whole burst and is not looked at while deselected.
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            wr_addr <= '0;
        end
        else if ((!active || last_slot) && !sel_n_s2)
        begin
            wr_addr <= addr_s2; // RL8
        end
    end

    // Each clock of a burst yields a rising beat and a falling beat, stored together as one pair.
    always_comb
    begin
        rise_beat = make_beat(wr_addr, beat_idx, pd_s2, pm_s2); // RL1
        fall_beat = make_beat(wr_addr, beat_idx | 2'h1, nd_s2, nm_s2); // RL1
        push_pair[0] = rise_beat;
        push_pair[1] = fall_beat;
    end

    // Deselected clocks push nothing; a full FIFO drops the pair.
    assign pushing = active && fifo_in_ready; // RL3

    // Sixteen pairs of headroom absorb bursts while the array side is stalled.
    beat_fifo #(
        .WIDTH(2 * BEAT_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .reset_n(reset_n),
        .in_data(push_pair),
        .in_valid(pushing),
        .in_ready(fifo_in_ready),
        .out_data(fifo_pair),
        .out_valid(fifo_valid),
        .out_ready(fifo_pop)
    );

    // Beats leave at most one every other clock: the rising half of the head pair first, then the falling half.
    assign emit = fifo_valid && beat_ready && !beat_valid;
    assign fifo_pop = emit && half_sel;

    // Selects which half of the head pair goes out next.
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            half_sel <= 1'b0;
        end
        else if (emit)
        begin
            half_sel <= !half_sel;
        end
    end

    // One-clock strobe; a gap clock follows every beat.
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            beat_valid <= 1'b0;
        end
        else
        begin
            beat_valid <= emit;
        end
    end

    // The output register is loaded only with a beat that is being shown.
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            beat_out <= '0;
        end
        else if (emit)
        begin
            beat_out <= fifo_pair[half_sel];
        end
    end

    // Mirrors the burst state one clock late, so it comes straight from a flop.
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            busy <= 1'b0;
        end
        else
        begin
            busy <= active;
        end
    end
endmodule

// >>> bench/wr_ctrl_model.sv
// Purpose: Controller model driving the write port pins.
// Assumes: Pins change on falling edges.
// Notes: Released lines show inverted values.
`timescale 1ns/1ns
module wr_ctrl_model
    import wr_capture_pkg::*;
(
    input wire logic clk, // Clock.
    output logic sel_n, // Select.
    output logic [ADDR_W-1:0] addr, // Address.
    output logic [15:0] d, // Rising, falling beats.
    output logic [3:0] m // Rising, falling masks.
);
    initial
    begin
        {sel_n, addr, d, m} = {1'b1, 40'h0};
    end
    // Data and masks follow the select by one clock, one word per clock.
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] dv, input logic [7:0] mv);
        @(negedge clk);
        sel_n = 1'b0;
        addr = a;
        @(negedge clk);
        sel_n = 1'b1;
        addr = ~a;
        d = dv[31:16];
        m = mv[7:4];
        @(negedge clk);
        d = dv[15:0];
        m = mv[3:0];
        @(negedge clk);
        {d, m} = ~{d, m};
    endtask
    task automatic noise(input int n);
        repeat (n)
        begin
            @(negedge clk);
            {addr, d, m} = ~{addr, d, m};
        end
    endtask
endmodule

// >>> bench/sram_write_port_capture_properties.sv
// Purpose: Port checks for the write-port capture.
// Assumes: One clock, synchronous reset.
// Notes: Bound to the capture module.
`timescale 1ns/1ns
module wr_capture_checker
    import wr_capture_pkg::*;
(
    input wire logic clk, // Clock.
    input wire logic reset_n, // Reset.
    input wire logic write_port_select_n, // Select.
    input wire logic [BEAT_W-1:0] beat_out, // Beat.
    input wire logic beat_valid, // Strobe.
    input wire logic beat_ready, // Accept.
    input wire logic busy // Burst.
);
    beat_t b;
    assign b = beat_out;
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    sequence s_quiet;
        write_port_select_n [*7];
    endsequence
    property p_lo; beat_valid && !b.keep[0] |-> b.data[3:0] == 4'h0; endproperty
    a_lo: assert property (p_lo) else $error("low nibble");
    property p_hi; beat_valid && !b.keep[1] |-> b.data[7:4] == 4'h0; endproperty
    a_hi: assert property (p_hi) else $error("high nibble");
    property p_sel; $rose(busy) |-> !$past(write_port_select_n, 4); endproperty
    a_sel: assert property (p_sel) else $error("start");
    property p_quiet; s_quiet |=> !busy; endproperty
    a_quiet: assert property (p_quiet) else $error("deselect");
    property p_gap; beat_valid |=> !beat_valid; endproperty
    a_gap: assert property (p_gap) else $error("rate");
    property p_rst; disable iff (1'b0) !reset_n |=> !busy && !beat_valid; endproperty
    a_rst: assert property (p_rst) else $error("reset");
    property p_two; $rose(busy) |=> busy; endproperty
    a_two: assert property (p_two) else $error("busy");
    property p_ans; $rose(busy) && beat_ready |-> ##[1:8] beat_valid; endproperty
    a_ans: assert property (p_ans) else $error("answer");
endmodule
bind sram_write_port_capture wr_capture_checker u_chk (.clk(clk), .reset_n(reset_n),
    .write_port_select_n(write_port_select_n), .beat_out(beat_out), .beat_valid(beat_valid),
    .beat_ready(beat_ready), .busy(busy));

// >>> bench/tb_sram_write_port_capture.sv
// Purpose: Bench for the write-port capture.
// Assumes: The controller model drives the pins.
// Notes: Captured beats are gathered in a queue.
`timescale 1ns/1ns
module tb_sram_write_port_capture
    import wr_capture_pkg::*;
    ;
    logic clk = 1'b0, reset_n = 1'b0, rdy = 1'b1, sel_n, bv, busy;
    logic [ADDR_W-1:0] addr;
    logic [15:0] d;
    logic [3:0] m;
    logic [BEAT_W-1:0] bo;
    int num_errors = 0, checked = 0;
    beat_t got[$];
    initial
    begin
        forever #2 clk = ~clk;
    end
    wr_ctrl_model u_ctl (.clk(clk), .sel_n(sel_n), .addr(addr), .d(d), .m(m));
    sram_write_port_capture u_dut (.clk(clk), .reset_n(reset_n), .write_port_select_n(sel_n), .addr_in(addr),
        .pos_data(d[15:8]), .neg_data(d[7:0]), .pos_mask_n(m[3:2]), .neg_mask_n(m[1:0]), .beat_out(bo),
        .beat_valid(bv), .beat_ready(rdy), .busy(busy));
    always @(posedge clk)
    begin
        if (bv === 1'b1)
            got.push_back(bo);
    end
    task automatic chk(input logic ok);
        checked++;
        if (ok !== 1'b1)
        begin
            num_errors++;
            $display("CHECK FAILED %0t beat mismatch", $time);
        end
    endtask
    task automatic expect_burst(input logic [ADDR_W-1:0] a, input logic [31:0] dv, input logic [7:0] mv);
        for (int c = 0; c < 60 && got.size() < BEATS; c++)
            @(negedge clk);
        for (int k = 0; k < BEATS; k++)
        begin
            logic [15:0] w;
            logic [3:0] wm;
            logic [7:0] x;
            logic [1:0] n;
            w = k[1] ? dv[15:0] : dv[31:16];
            wm = k[1] ? mv[3:0] : mv[7:4];
            x = k[0] ? w[7:0] : w[15:8];
            n = k[0] ? wm[1:0] : wm[3:2];
            chk(got.size() > 0 && got.pop_front() === {a, k[1:0], x & {{4{~n[1]}}, {4{~n[0]}}}, ~n});
        end
    endtask
    task automatic t_masks();
        for (logic [2:0] i = 0; i < 4; i++)
        begin
            logic [31:0] dv;
            logic [7:0] mv;
            dv = {16'h5ac3 ^ 16'(i), 16'hc3a5 + 16'(i)};
            mv = {i[1:0], ~i[1:0], ~i[1:0], i[1:0]};
            u_ctl.wr(20'h8f0a0 + 20'(i), dv, mv);
            expect_burst(20'h8f0a0 + 20'(i), dv, mv);
        end
        $display("t_masks done");
    endtask
    task automatic t_desel();
        u_ctl.noise(30);
        chk(got.size() == 0 && busy === 1'b0);
        $display("t_desel done");
    endtask
    task automatic t_fill();
        rdy = 1'b0;
        for (int i = 0; i < 4; i++)
            u_ctl.wr(20'h00f00 + 20'(i), {16'h96e1 + 16'(i), 16'h1e69 ^ 16'(i)}, 8'h00);
        repeat (20) @(negedge clk);
        chk(got.size() == 0);
        rdy = 1'b1;
        for (int i = 0; i < 4; i++)
            expect_burst(20'h00f00 + 20'(i), {16'h96e1 + 16'(i), 16'h1e69 ^ 16'(i)}, 8'h00);
        $display("t_fill done");
    endtask
    task automatic give_verdict();
        $display("checked %0d num_errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial
    begin
        repeat (16) @(negedge clk);
        reset_n = 1'b1;
        t_masks();
        t_desel();
        t_fill();
        give_verdict();
    end
    initial
    begin
        #20000;
        num_errors++;
        give_verdict();
    end
endmodule
